// >>> hiv_irq_decode.sv
// register address decode, feature mode register and scalar/vectored interrupt combining
`timescale 1ns/100ps

// Overview of operation
// - decode eight-bit host register address
// - 00 to 7F, except 60h to 62h, selects the mac registers
// - 80 to AF selects the phy registers
// - B0 to CF selects the address filter
// - D0 to DF selects clock recovery unit
// - E0 to FF reserved, nothing there
// - feature mode register sits at 60h
// - scalar mode drives four separate interrupt lines
// - third line: self-test done or queue two
// - scalar scheme after reset
// - mode bit 10 selects vectored, fourth line
// - vector bits 0-5 mac halves, 6 phy
// - vector and mask bits 7-15 read zero
// - vector bit counts only when mask set
// - mask register clears at reset
// - no re-raise until source register read
// - mode bit 11 enables dual receive queues
// - mode bit 14 holds first async queue
// - mode bit 15 loops tx back to rx
// - mode bits 12-13 place frame control
// - mode register resets, writable only in init/memory-active
module hiv_irq_decode #(
  parameter int NUM_SRC = hiv_pkg::HIV_NUM_SRC
) (
  input  wire logic               CLK_SYS_IN,
  input  wire logic               RESET_N_IN,
  input  wire logic [7:0]         NP_ADDR_IN,
  input  wire logic [15:0]        NP_WDATA_IN,
  input  wire logic               NP_WR_IN,
  input  wire logic               NP_RD_IN,
  input  wire logic               DEV_MODE_WRITABLE_IN,
  input  wire logic               MAC_IRQ_A_IN,
  input  wire logic               MAC_IRQ_B_IN,
  input  wire logic               BIST_DONE_IN,
  input  wire logic               RXQ2_CHANGE_IN,
  input  wire logic               PHY_IRQ_IN,
  input  wire logic [NUM_SRC-1:0] SRC_PEND_IN,
  input  wire logic [NUM_SRC-1:0] SRC_READ_IN,
  output logic [15:0]             NP_RDATA_OUT,
  output logic                    NP_RDVALID_OUT,
  output logic [7:0]              REG_ADDR_OUT,
  output logic [15:0]             REG_WDATA_OUT,
  output logic                    REG_WR_OUT,
  output logic                    REG_RD_OUT,
  output logic                    MAC_SEL_OUT,
  output logic                    PHY_SEL_OUT,
  output logic                    AF_SEL_OUT,
  output logic                    CDR_SEL_OUT,
  output logic [15:0]             FEATURE_MODE_OUT,
  output logic                    IRQ_MAC_A_OUT,
  output logic                    IRQ_MAC_B_OUT,
  output logic                    IRQ_MAC_BIST_OUT,
  output logic                    IRQ_PHY_OUT
);
  import hiv_pkg::*;

  // ==========================================================================
  // reset release
  logic       rst_n;
  logic [1:0] rst_sync_q;

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================================
  // address decode
  function automatic hiv_range_t range_of(input logic [7:0] a);
    if (a <= HIV_MAC_HI) begin
      return HIV_RANGE_MAC;
    end else if (a <= HIV_PHY_HI) begin
      return HIV_RANGE_PHY;
    end else if (a <= HIV_AF_HI) begin
      return HIV_RANGE_AF;
    end else if (a <= HIV_CDR_HI) begin
      return HIV_RANGE_CDR;
    end else begin
      return HIV_RANGE_RSVD;
    end
  endfunction

  function automatic logic owned(input logic [7:0] a);
    return (a == HIV_FEATURE_MODE_OFS) || (a == HIV_IRQ_VECTOR_OFS) || (a == HIV_IRQ_MASK_OFS);
  endfunction

  hiv_range_t range;
  logic       access;
  logic       own_hit;

  assign range   = range_of(NP_ADDR_IN);
  assign access  = NP_WR_IN || NP_RD_IN;
  assign own_hit = owned(NP_ADDR_IN);

  // forward accesses to the sub-block register sets, one cycle later
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      REG_ADDR_OUT  <= 8'h00;
      REG_WDATA_OUT <= 16'h0000;
      REG_WR_OUT    <= 1'b0;
      REG_RD_OUT    <= 1'b0;
      MAC_SEL_OUT   <= 1'b0;
      PHY_SEL_OUT   <= 1'b0;
      AF_SEL_OUT    <= 1'b0;
      CDR_SEL_OUT   <= 1'b0;
    end else begin
      REG_ADDR_OUT  <= NP_ADDR_IN;
      REG_WDATA_OUT <= NP_WDATA_IN;
      REG_WR_OUT    <= NP_WR_IN;
      REG_RD_OUT    <= NP_RD_IN;
      MAC_SEL_OUT   <= access && !own_hit && (range == HIV_RANGE_MAC);
      PHY_SEL_OUT   <= access && (range == HIV_RANGE_PHY);
      AF_SEL_OUT    <= access && (range == HIV_RANGE_AF);
      CDR_SEL_OUT   <= access && (range == HIV_RANGE_CDR);
    end
  end

  // ==========================================================================
  // feature mode register
  logic [15:0] feature_mode_q;

  // writes outside init/memory-active are dropped silently, as the mode
  // bits steer datapaths that must not change under live traffic
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      feature_mode_q <= HIV_FEATURE_MODE_RST;
    end else if (NP_WR_IN && NP_ADDR_IN == HIV_FEATURE_MODE_OFS && DEV_MODE_WRITABLE_IN) begin
      feature_mode_q <= NP_WDATA_IN;
    end
  end
  // bits 11, 14, 15, 8 and 13:12 reach their datapaths here
  assign FEATURE_MODE_OUT = feature_mode_q;

  logic vec_en;
  assign vec_en = feature_mode_q[HIV_FM_VECTORED_BIT];

  // ==========================================================================
  // vector and mask registers
  logic [NUM_SRC-1:0] vector_q;
  logic [NUM_SRC-1:0] mask_q;
  logic               any_src_read;

  assign any_src_read = |SRC_READ_IN;

  // a new pending event wins over a read in the same cycle
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      vector_q <= HIV_IRQ_VECTOR_RST[NUM_SRC-1:0];
    end else begin
      vector_q <= (vector_q & ~SRC_READ_IN) | SRC_PEND_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= HIV_IRQ_MASK_RST[NUM_SRC-1:0];
    end else if (NP_WR_IN && NP_ADDR_IN == HIV_IRQ_MASK_OFS) begin
      mask_q <= NP_WDATA_IN[NUM_SRC-1:0];
    end
  end

  // ==========================================================================
  // vectored interrupt
  hiv_virq_state_t virq_q;
  hiv_virq_state_t virq_d;
  logic            masked_pend;

  assign masked_pend = |(vector_q & mask_q);

  always_comb begin
    virq_d = virq_q;
    unique case (virq_q)
      HIV_VIRQ_ARMED: begin
        if (vec_en && masked_pend) begin
          virq_d = HIV_VIRQ_RAISED;
        end
      end
      HIV_VIRQ_RAISED: begin
        // stays up until a source register is read or vectored mode is switched off
        if (any_src_read || !vec_en) begin
          virq_d = HIV_VIRQ_ARMED;
        end
      end
      default: begin
        virq_d = HIV_VIRQ_ARMED;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      virq_q <= HIV_VIRQ_ARMED;
    end else begin
      virq_q <= virq_d;
    end
  end

  // ==========================================================================
  // interrupt outputs: scalar lines unless vectored mode is on
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_MAC_A_OUT    <= 1'b0;
      IRQ_MAC_B_OUT    <= 1'b0;
      IRQ_MAC_BIST_OUT <= 1'b0;
      IRQ_PHY_OUT      <= 1'b0;
    end else if (vec_en) begin
      IRQ_MAC_A_OUT    <= 1'b0;
      IRQ_MAC_B_OUT    <= 1'b0;
      IRQ_MAC_BIST_OUT <= 1'b0;
      IRQ_PHY_OUT      <= (virq_d == HIV_VIRQ_RAISED);
    end else begin
      IRQ_MAC_A_OUT    <= MAC_IRQ_A_IN;
      IRQ_MAC_B_OUT    <= MAC_IRQ_B_IN;
      IRQ_MAC_BIST_OUT <= BIST_DONE_IN || RXQ2_CHANGE_IN;
      IRQ_PHY_OUT      <= PHY_IRQ_IN;
    end
  end

  // ==========================================================================
  // read answers for owned registers and the reserved range
  logic [15:0] rdata_d;

  always_comb begin
    rdata_d = 16'h0000;
    if (NP_ADDR_IN == HIV_FEATURE_MODE_OFS) begin
      rdata_d = feature_mode_q;
    end else if (NP_ADDR_IN == HIV_IRQ_VECTOR_OFS) begin
      rdata_d[NUM_SRC-1:0] = vector_q;
    end else if (NP_ADDR_IN == HIV_IRQ_MASK_OFS) begin
      rdata_d[NUM_SRC-1:0] = mask_q;
    end
  end

  // reserved addresses answer zero so the host never hangs on them
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      NP_RDATA_OUT   <= 16'h0000;
      NP_RDVALID_OUT <= 1'b0;
    end else begin
      NP_RDVALID_OUT <= NP_RD_IN && (own_hit || range == HIV_RANGE_RSVD);
      NP_RDATA_OUT   <= NP_RD_IN ? rdata_d : 16'h0000;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!rst_n);

  property p_mac_sel;
    access && NP_ADDR_IN < HIV_PHY_LO && !own_hit |=> MAC_SEL_OUT && !PHY_SEL_OUT;
  endproperty
  a_mac_sel: assert property (p_mac_sel) else $error("mac select missing");

  property p_phy_sel;
    access && NP_ADDR_IN >= HIV_PHY_LO && NP_ADDR_IN < HIV_AF_LO |=> PHY_SEL_OUT && !AF_SEL_OUT;
  endproperty
  a_phy_sel: assert property (p_phy_sel) else $error("phy select missing");

  property p_af_sel;
    access && NP_ADDR_IN >= HIV_AF_LO && NP_ADDR_IN < HIV_CDR_LO |=> AF_SEL_OUT && !CDR_SEL_OUT;
  endproperty
  a_af_sel: assert property (p_af_sel) else $error("filter select missing");

  property p_cdr_sel;
    access && NP_ADDR_IN >= HIV_CDR_LO && NP_ADDR_IN < HIV_RSVD_LO |=> CDR_SEL_OUT && !MAC_SEL_OUT;
  endproperty
  a_cdr_sel: assert property (p_cdr_sel) else $error("recovery select missing");

  property p_rsvd_read;
    NP_RD_IN && NP_ADDR_IN >= HIV_RSVD_LO
      |=> NP_RDVALID_OUT && NP_RDATA_OUT == 16'h0000 && !(MAC_SEL_OUT || PHY_SEL_OUT || AF_SEL_OUT || CDR_SEL_OUT);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read wrong");

  property p_mode_write;
    NP_WR_IN && NP_ADDR_IN == HIV_FEATURE_MODE_OFS && DEV_MODE_WRITABLE_IN
      |=> feature_mode_q == $past(NP_WDATA_IN);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_mode_locked;
    !(NP_WR_IN && NP_ADDR_IN == HIV_FEATURE_MODE_OFS && DEV_MODE_WRITABLE_IN) |=> $stable(feature_mode_q);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("mode changed while locked");

  property p_scalar_lines;
    !vec_en |=> IRQ_MAC_A_OUT == $past(MAC_IRQ_A_IN) && IRQ_MAC_B_OUT == $past(MAC_IRQ_B_IN)
      && IRQ_PHY_OUT == $past(PHY_IRQ_IN);
  endproperty
  a_scalar_lines: assert property (p_scalar_lines) else $error("scalar line wrong");

  property p_bist_line;
    !vec_en && (BIST_DONE_IN || RXQ2_CHANGE_IN) |=> IRQ_MAC_BIST_OUT;
  endproperty
  a_bist_line: assert property (p_bist_line) else $error("third line not raised");

  property p_vec_quiet;
    vec_en |=> !IRQ_MAC_A_OUT && !IRQ_MAC_B_OUT && !IRQ_MAC_BIST_OUT;
  endproperty
  a_vec_quiet: assert property (p_vec_quiet) else $error("scalar line active in vectored mode");

  property p_reserved_zero;
    NP_RD_IN && (NP_ADDR_IN == HIV_IRQ_VECTOR_OFS || NP_ADDR_IN == HIV_IRQ_MASK_OFS)
      |=> NP_RDVALID_OUT && NP_RDATA_OUT[15:7] == 9'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_mask_blocks;
    vec_en && virq_q == HIV_VIRQ_ARMED && !masked_pend |=> !IRQ_PHY_OUT;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked source raised interrupt");

  property p_mask_passes;
    vec_en && virq_q == HIV_VIRQ_ARMED && masked_pend |=> IRQ_PHY_OUT;
  endproperty
  a_mask_passes: assert property (p_mask_passes) else $error("unmasked source not raised");

  sequence s_raised_unread;
    virq_q == HIV_VIRQ_RAISED && vec_en && !any_src_read;
  endsequence

  sequence s_held;
    virq_q == HIV_VIRQ_RAISED && IRQ_PHY_OUT;
  endsequence

  property p_no_rearm;
    s_raised_unread |=> s_held;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("vectored interrupt rearmed without read");

  property p_drop_on_read;
    virq_q == HIV_VIRQ_RAISED && any_src_read |=> !IRQ_PHY_OUT ##1 (IRQ_PHY_OUT == $past(vec_en && masked_pend));
  endproperty
  a_drop_on_read: assert property (p_drop_on_read) else $error("vectored interrupt not cleared");

  property p_vector_set;
    |SRC_PEND_IN |=> (vector_q & $past(SRC_PEND_IN)) == $past(SRC_PEND_IN);
  endproperty
  a_vector_set: assert property (p_vector_set) else $error("pending event lost");

  property p_vector_clear;
    |(SRC_READ_IN & ~SRC_PEND_IN) |=> (vector_q & $past(SRC_READ_IN & ~SRC_PEND_IN)) == '0;
  endproperty
  a_vector_clear: assert property (p_vector_clear) else $error("vector bit not cleared on read");

endmodule // hiv_irq_decode

// >>> hiv_pkg.sv
// shared constants for the host interrupt vector and register decode block
package hiv_pkg;

  // ==========================================================================
  // address map
  localparam logic [7:0] HIV_MAC_LO   = 8'h00;
  localparam logic [7:0] HIV_MAC_HI   = 8'h7f;
  localparam logic [7:0] HIV_PHY_LO   = 8'h80;
  localparam logic [7:0] HIV_PHY_HI   = 8'haf;
  localparam logic [7:0] HIV_AF_LO    = 8'hb0;
  localparam logic [7:0] HIV_AF_HI    = 8'hcf;
  localparam logic [7:0] HIV_CDR_LO   = 8'hd0;
  localparam logic [7:0] HIV_CDR_HI   = 8'hdf;
  localparam logic [7:0] HIV_RSVD_LO  = 8'he0;

  // ==========================================================================
  // registers owned by this block
  localparam logic [7:0] HIV_FEATURE_MODE_OFS = 8'h60;
  localparam logic [7:0] HIV_IRQ_VECTOR_OFS   = 8'h61;
  localparam logic [7:0] HIV_IRQ_MASK_OFS     = 8'h62;

  localparam logic [15:0] HIV_FEATURE_MODE_RST = 16'h0000;
  localparam logic [6:0]  HIV_IRQ_MASK_RST     = 7'h00;
  localparam logic [6:0]  HIV_IRQ_VECTOR_RST   = 7'h00;

  // ==========================================================================
  // feature mode register fields
  localparam int HIV_FM_DUAL_ATTACH_BIT  = 8;
  localparam int HIV_FM_VECTORED_BIT     = 10;
  localparam int HIV_FM_DUAL_RXQ_BIT     = 11;
  localparam int HIV_FM_FC_POS_LSB       = 12;
  localparam int HIV_FM_TX_ON_CMD_BIT    = 14;
  localparam int HIV_FM_LOOPBACK_BIT     = 15;

  // vector and mask: six mac status halves then the phy event register
  localparam int HIV_NUM_SRC = 7;

  // ==========================================================================
  // types
  typedef enum logic [4:0] {
    HIV_RANGE_MAC  = 5'h01,
    HIV_RANGE_PHY  = 5'h02,
    HIV_RANGE_AF   = 5'h04,
    HIV_RANGE_CDR  = 5'h08,
    HIV_RANGE_RSVD = 5'h10
  } hiv_range_t;

  typedef enum logic [1:0] {
    HIV_VIRQ_ARMED  = 2'h1,
    HIV_VIRQ_RAISED = 2'h2
  } hiv_virq_state_t;

endpackage : hiv_pkg

// >>> hiv_np_model.sv
// node processor model: register cycles and vectored interrupt service
`timescale 1ns/100ps
module hiv_np_model #(
  parameter bit EXT_PHY = 1'b1
) (
  input  wire logic                       clk_in,
  input  wire logic [15:0]                rdata_in,
  input  wire logic                       rdvalid_in,
  output logic      [7:0]                 addr_out,
  output logic      [15:0]                wdata_out,
  output logic                            wr_out,
  output logic                            rd_out,
  output logic      [hiv_pkg::HIV_NUM_SRC-1:0] src_read_out
);
  import hiv_pkg::*;

  initial begin
    addr_out = 8'h00;
    wdata_out = 16'h0000;
    wr_out = 1'h0;
    rd_out = 1'h0;
    src_read_out = '0;
  end

  // ==========================================================================
  // one-cycle strobe; idle lines flip so stale values never look valid
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= (w && a == HIV_FEATURE_MODE_OFS && !EXT_PHY) ? (d & 16'hfeff) : d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    wr_out <= 1'h0;
    rd_out <= 1'h0;
    addr_out <= ~a;
    wdata_out <= ~d;
    #1;
  endtask

  // ==========================================================================
  // reads the vector only and names the lowest unmasked pending source; masked bits did not raise
  // the line, so they are left pending for a later pass
  task automatic service(input logic [15:0] msk, output logic [15:0] vec, output int src);
    access(1'h0, HIV_IRQ_VECTOR_OFS, 16'h0000);
    vec = rdvalid_in ? rdata_in : 16'hdead;
    src = -1;
    for (int i = HIV_NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i] && msk[i])
        src = i;
    end
  endtask

  task automatic ack(input int src);
    @(posedge clk_in);
    src_read_out[src] <= 1'h1;
    @(posedge clk_in);
    src_read_out <= '0;
    #1;
  endtask
endmodule // hiv_np_model

// >>> tb_top.sv
// self-checking bench for register decode and interrupt combining
`timescale 1ns/100ps
module tb_top;
  import hiv_pkg::*;
  typedef struct packed { logic [7:0] addr; logic [3:0] sel; logic vld; } hiv_row_t;

  logic        clk_sys, reset_n, mode_wr_ok, rdvalid, reg_wr, reg_rd;
  logic        mac_sel, phy_sel, af_sel, cdr_sel, irq_a, irq_b, irq_bist, irq_phy;
  logic [4:0]  irq_in;
  logic [6:0]  pend, src_read;
  logic [7:0]  np_addr, reg_addr;
  logic [15:0] np_wdata, rdata, reg_wdata, fmode, vec;
  logic        np_wr, np_rd;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          src;
  hiv_row_t    rows [15] = '{{8'h00, 4'h8, 1'h0}, {8'h5f, 4'h8, 1'h0}, {8'h63, 4'h8, 1'h0},
                             {8'h7f, 4'h8, 1'h0}, {8'h60, 4'h0, 1'h1}, {8'h61, 4'h0, 1'h1},
                             {8'h62, 4'h0, 1'h1}, {8'h80, 4'h4, 1'h0}, {8'haf, 4'h4, 1'h0},
                             {8'hb0, 4'h2, 1'h0}, {8'hcf, 4'h2, 1'h0}, {8'hd0, 4'h1, 1'h0},
                             {8'hdf, 4'h1, 1'h0}, {8'he0, 4'h0, 1'h1}, {8'hff, 4'h0, 1'h1}};

  hiv_irq_decode u_hiv_irq_decode (
    .CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n), .NP_ADDR_IN(np_addr), .NP_WDATA_IN(np_wdata),
    .NP_WR_IN(np_wr), .NP_RD_IN(np_rd), .DEV_MODE_WRITABLE_IN(mode_wr_ok), .MAC_IRQ_A_IN(irq_in[0]),
    .MAC_IRQ_B_IN(irq_in[1]), .BIST_DONE_IN(irq_in[2]), .RXQ2_CHANGE_IN(irq_in[3]), .PHY_IRQ_IN(irq_in[4]),
    .SRC_PEND_IN(pend), .SRC_READ_IN(src_read), .NP_RDATA_OUT(rdata), .NP_RDVALID_OUT(rdvalid),
    .REG_ADDR_OUT(reg_addr), .REG_WDATA_OUT(reg_wdata), .REG_WR_OUT(reg_wr), .REG_RD_OUT(reg_rd),
    .MAC_SEL_OUT(mac_sel), .PHY_SEL_OUT(phy_sel), .AF_SEL_OUT(af_sel), .CDR_SEL_OUT(cdr_sel),
    .FEATURE_MODE_OUT(fmode), .IRQ_MAC_A_OUT(irq_a), .IRQ_MAC_B_OUT(irq_b),
    .IRQ_MAC_BIST_OUT(irq_bist), .IRQ_PHY_OUT(irq_phy));

  hiv_np_model u_hiv_np_model (
    .clk_in(clk_sys), .rdata_in(rdata), .rdvalid_in(rdvalid), .addr_out(np_addr),
    .wdata_out(np_wdata), .wr_out(np_wr), .rd_out(np_rd), .src_read_out(src_read));

  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset;
    reset_n <= 1'h0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    u_hiv_np_model.access(1'h0, a, 16'h0000);
    chk(what, exp, rdata);
  endtask

  // bounded wait on the vectored line; running out ends the run
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 8; i++) begin
      settle(1);
      if (irq_phy === exp)
        return;
    end
    chk("irq wait", {15'h0, exp}, {15'h0, irq_phy});
    end_sim();
  endtask

  function automatic logic [15:0] outs();
    return {12'h0, irq_a, irq_b, irq_bist, irq_phy};
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    reset_n = 1'h0;
    mode_wr_ok = 1'h0;
    irq_in = '0;
    pend = '0;
    do_reset();
    foreach (rows[i]) begin
      u_hiv_np_model.access(1'h0, rows[i].addr, 16'h0000);
      chk("selects", {12'h0, rows[i].sel}, {12'h0, mac_sel, phy_sel, af_sel, cdr_sel});
      chk("rdvalid", {15'h0, rows[i].vld}, {15'h0, rdvalid});
      chk("rdata", 16'h0000, rdata);
      chk("reg addr", {8'h0, rows[i].addr}, {8'h0, reg_addr});
      chk("reg strobes", 16'h0001, {14'h0, reg_wr, reg_rd});
    end
    u_hiv_np_model.access(1'h1, 8'h90, 16'ha55a);
    chk("fwd write", 16'h0006, {13'h0, phy_sel, reg_wr, reg_rd});
    chk("fwd wdata", 16'ha55a, reg_wdata);
    $display("test decode done");
    u_hiv_np_model.access(1'h1, HIV_FEATURE_MODE_OFS, 16'hf900);
    chk("mode locked", 16'h0000, fmode);
    mode_wr_ok <= 1'h1;
    u_hiv_np_model.access(1'h1, HIV_FEATURE_MODE_OFS, 16'hf900);
    chk("mode bits", 16'hf900, fmode);
    rd_chk("mode read", HIV_FEATURE_MODE_OFS, 16'hf900);
    u_hiv_np_model.access(1'h1, HIV_IRQ_MASK_OFS, 16'hffff);
    rd_chk("mask read", HIV_IRQ_MASK_OFS, 16'h007f);
    u_hiv_np_model.access(1'h1, HIV_IRQ_VECTOR_OFS, 16'hffff);
    rd_chk("vector ro", HIV_IRQ_VECTOR_OFS, 16'h0000);
    u_hiv_np_model.access(1'h1, 8'he0, 16'hffff);
    rd_chk("reserved", 8'he0, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      irq_in <= 5'h01 << i;
      settle(2);
      chk("scalar", {12'h0, irq_in[0], irq_in[1], irq_in[2] | irq_in[3], irq_in[4]}, outs());
    end
    $display("test scalar done");
    u_hiv_np_model.access(1'h1, HIV_IRQ_MASK_OFS, 16'h007e);
    u_hiv_np_model.access(1'h1, HIV_FEATURE_MODE_OFS, 16'h0400);
    irq_in <= 5'h1f;
    pend <= 7'h01;
    settle(4);
    chk("masked", 16'h0000, outs());
    pend <= 7'h09;
    wait_irq(1'h1);
    settle(4);
    chk("held", 16'h0001, outs());
    u_hiv_np_model.service(16'h007e, vec, src);
    chk("vector", 16'h0009, vec);
    pend <= 7'h01;
    u_hiv_np_model.ack(src);
    chk("rearm", 16'h0000, outs());
    rd_chk("vector after", HIV_IRQ_VECTOR_OFS, 16'h0001);
    settle(3);
    chk("still masked", 16'h0000, outs());
    u_hiv_np_model.access(1'h1, HIV_IRQ_MASK_OFS, 16'h007f);
    wait_irq(1'h1);
    u_hiv_np_model.access(1'h1, HIV_FEATURE_MODE_OFS, 16'h0000);
    settle(2);
    chk("back scalar", 16'h000f, outs());
    $display("test vectored done");
    reset_n <= 1'h0;
    settle(2);
    chk("in reset", 16'h0000, fmode | outs());
    do_reset();
    rd_chk("mask reset", HIV_IRQ_MASK_OFS, 16'h0000);
    rd_chk("mode reset", HIV_FEATURE_MODE_OFS, 16'h0000);
    settle(2);
    chk("scalar reset", 16'h000f, outs());
    $display("test reset done");
    end_sim();
  end
endmodule // tb_top
